/* rtl/scm_synth_control.sv */
// Purpose: Digital control of a fractional-N synthesizer with lock detect.
// Assumes: mclk is the reference clock; APB and serial pins share it.
// Notes: Calibration length is modelled by fixed state machine tick counts.
`timescale 1ns/10ps
`default_nettype none
module scm_synth_control (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sck,
    input wire logic sdi,
    input wire logic chipSelectN,
    input wire logic vtuneLocked,
    input wire logic pfdTick,
    output logic muxStatusOut,
    output logic rfOutEnable,
    output logic modulatorReset,
    output logic [15:0] feedbackDivide,
    output logic [2:0] modOrder,
    output logic refDoublerEn,
    output logic [2:0] refMultiplier,
    output logic bothEdges,
    output logic [3:0] pfdMulFactor,
    output logic [15:0] pfdDivFactor,
    output logic detectorDelaySel,
    output logic calBusy
);
    logic [15:0] regs_ff [0:scm_pkg::NUM_REGS-1];
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic mux_status_out_ff;
    logic modRst_ff;
    logic [15:0] fbDiv_ff;
    logic [31:0] acc_ff;
    logic [15:0] cnt_ff;
    scm_pkg::scm_lock_e state_ff;
    scm_pkg::scm_lock_e nxtState;
    logic [15:0] nxtCnt;
    logic tick;
    logic [3:0] apbIdx;
    logic apbMapped;
    logic apbWr;
    logic spiWr;
    logic wrEn;
    logic [3:0] wrIdx;
    logic [15:0] wrRaw;
    logic [15:0] wrVal;
    logic r0Wr;
    logic [2:0] newMult;
    logic multOk;
    logic [1:0] calClkDiv;
    logic lockDetectKind;
    logic muteEn;
    logic muxReadback;
    logic [15:0] lockDetectDelay;
    logic [31:0] fracNumerator;
    logic [31:0] fracDenominator;
    logic [31:0] effDen;
    logic [32:0] accSum;
    logic accCarry;
    logic [15:0] calLen;
    logic lockDetect;
    logic [1:0] tuneLockReadback;
    logic [15:0] statusWord;
    logic nxtMux;

    scm_spi_if spiBus ();

    scm_spi_slave u_spi (
        .mclk(mclk),
        .rst_n(rst_n),
        .sck(sck),
        .sdi(sdi),
        .chipSelectN(chipSelectN),
        .bus(spiBus)
    );

    scm_tick_div u_tick (
        .mclk(mclk),
        .rst_n(rst_n),
        .calClkDiv(calClkDiv),
        .tick(tick)
    );

    function automatic logic [15:0] readReg(input logic [3:0] idx);
        logic [15:0] val;
        val = 16'h0000;
        if (idx == scm_pkg::IDX_STAT) begin
            val = statusWord;
        end else if (idx < scm_pkg::IDX_STAT) begin
            val = regs_ff[idx];
        end
        return val;
    endfunction : readReg

    // Field decode.
    assign calClkDiv = regs_ff[1][scm_pkg::CFG_DIV_LSB +: 2];
    assign refDoublerEn = regs_ff[1][scm_pkg::CFG_DBL_BIT];
    assign refMultiplier = regs_ff[1][scm_pkg::CFG_REF_MULTIPLIER_LSB +: 3];
    assign lockDetectKind = regs_ff[1][scm_pkg::CFG_KIND_BIT];
    assign muteEn = regs_ff[1][scm_pkg::CFG_MUTE_BIT];
    assign modOrder = regs_ff[1][scm_pkg::CFG_ORD_LSB +: 3];
    assign muxReadback = regs_ff[1][scm_pkg::CFG_MUX_BIT];
    assign detectorDelaySel = regs_ff[1][scm_pkg::CFG_PDLY_BIT];
    assign lockDetectDelay = regs_ff[2];
    assign fracNumerator = {regs_ff[6], regs_ff[5]};
    assign fracDenominator = {regs_ff[8], regs_ff[7]};
    assign effDen = (fracDenominator == 32'h0) ? 32'h1 : fracDenominator;

    // Reference path: the host keeps doubler and multiplier apart.
    assign bothEdges = refDoublerEn || (refMultiplier != scm_pkg::REF_MULTIPLIER_BYPASS);
    assign pfdMulFactor = {1'b0, refMultiplier} << refDoublerEn;
    assign pfdDivFactor = {8'h00, regs_ff[3][7:0]} * {8'h00, regs_ff[3][15:8]};

    // Register access: a serial write stalls a coincident APB access.
    assign apbIdx = paddr[5:2];
    assign apbMapped = (paddr[11:6] == 6'h0) && (paddr[1:0] == 2'h0)
                       && (apbIdx <= scm_pkg::IDX_STAT);
    assign pready = !spiBus.wrStb;
    assign apbWr = psel && penable && pwrite && pready && apbMapped;
    assign spiWr = spiBus.wrStb && (spiBus.addr[6:4] == 3'h0);
    assign wrEn = (spiWr || apbWr) && (wrIdx != scm_pkg::IDX_STAT);
    assign wrIdx = spiBus.wrStb ? spiBus.addr[3:0] : apbIdx;
    assign wrRaw = spiBus.wrStb ? spiBus.wdata : pwdata[15:0];
    assign newMult = wrRaw[scm_pkg::CFG_REF_MULTIPLIER_LSB +: 3];
    assign multOk = (newMult == scm_pkg::REF_MULTIPLIER_BYPASS)
                    || (newMult >= scm_pkg::REF_MULTIPLIER_MIN);
    assign wrVal = (wrIdx != scm_pkg::IDX_CFG || multOk) ? wrRaw
        : {wrRaw[15:6], refMultiplier, wrRaw[2:0]};
    assign r0Wr = wrEn && (wrIdx == scm_pkg::IDX_CTRL0);
    // A function read in a continuous assignment would miss register updates.
    always_comb begin
        spiBus.rdata = readReg(spiBus.addr[3:0] | {4{|spiBus.addr[6:4]}});
    end

    generate
        for (genvar gi = 0; gi < scm_pkg::NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_ff[gi] <= scm_pkg::REG_RST[gi];
                end else if (wrEn && wrIdx == 4'(gi)) begin
                    regs_ff[gi] <= wrVal;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff <= 32'h0;
            pslverr_ff <= 1'b0;
        end else if (psel && !penable) begin
            prdata_ff <= {16'h0000, readReg(apbIdx)};
            pslverr_ff <= !apbMapped;
        end
    end
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff && psel && penable;

    // Calibration and lock detect sequencing.
    assign calLen = regs_ff[0][scm_pkg::CTRL0_FCAL_BIT]
        ? scm_pkg::AMP_CAL_TICKS + scm_pkg::FREQ_CAL_TICKS
        : scm_pkg::AMP_CAL_TICKS;

    always_comb begin
        nxtState = state_ff;
        nxtCnt = cnt_ff;
        if (r0Wr) begin
            nxtState = scm_pkg::ST_CAL;
            nxtCnt = 16'h0;
        end else if (tick) begin
            case (state_ff)
                scm_pkg::ST_CAL: begin
                    nxtCnt = cnt_ff + 16'h1;
                    if (nxtCnt >= calLen) begin
                        nxtCnt = 16'h0;
                        nxtState = (lockDetectDelay == 16'h0)
                            ? scm_pkg::ST_LOCK : scm_pkg::ST_DELAY;
                    end
                end
                scm_pkg::ST_DELAY: begin
                    nxtCnt = cnt_ff + 16'h1;
                    if (nxtCnt >= lockDetectDelay) begin
                        nxtState = scm_pkg::ST_LOCK;
                    end
                end
                scm_pkg::ST_IDLE,
                scm_pkg::ST_LOCK: begin
                    nxtCnt = 16'h0;
                end
                default: begin
                    nxtState = scm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= scm_pkg::ST_IDLE;
            cnt_ff <= 16'h0;
        end else begin
            state_ff <= nxtState;
            cnt_ff <= nxtCnt;
        end
    end

    assign calBusy = (state_ff == scm_pkg::ST_CAL);
    assign lockDetect = lockDetectKind ? vtuneLocked
        : (state_ff == scm_pkg::ST_LOCK);
    assign tuneLockReadback = (lockDetectKind && vtuneLocked)
        ? scm_pkg::TUNE_LOCKED : scm_pkg::TUNE_UNLOCKED;
    assign rfOutEnable = !(muteEn && !lockDetect);
    assign statusWord = {8'h00, bothEdges, !rfOutEnable, tuneLockReadback,
                         lockDetect, state_ff, calBusy};

    // The pin returns serial read data or the lock indication.
    assign nxtMux = muxReadback ? (spiBus.readData && spiBus.sdo)
                                : lockDetect;

    // Fractional accumulator; orders above one share the first-order carry.
    assign accSum = {1'b0, acc_ff} + {1'b0, fracNumerator};
    assign accCarry = (modOrder != 3'h0) && (accSum >= {1'b0, effDen});

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= 32'h0;
            fbDiv_ff <= 16'h0;
            modRst_ff <= 1'b0;
            mux_status_out_ff <= 1'b0;
        end else begin
            modRst_ff <= r0Wr;
            mux_status_out_ff <= nxtMux;
            if (r0Wr || modOrder == 3'h0) begin
                acc_ff <= 32'h0;
            end else if (pfdTick) begin
                acc_ff <= accCarry ? 32'(accSum - {1'b0, effDen}) : accSum[31:0];
            end
            if (pfdTick) begin
                fbDiv_ff <= regs_ff[4] + {15'h0, accCarry};
            end
        end
    end
    assign muxStatusOut = mux_status_out_ff;
    assign modulatorReset = modRst_ff;
    assign feedbackDivide = fbDiv_ff;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_mute;
        (muteEn && !lockDetectKind && state_ff != scm_pkg::ST_LOCK) |-> !rfOutEnable;
    endproperty
    a_mute: assert property (p_mute)
        else $error("Outputs on while muted and unlocked.");

    property p_cal_low;
        (!lockDetectKind && !muxReadback && state_ff != scm_pkg::ST_LOCK) |=> !muxStatusOut;
    endproperty
    a_cal_low: assert property (p_cal_low)
        else $error("Lock pin high before calibration and delay ended.");

    property p_mod_rst;
        r0Wr |=> (modulatorReset && acc_ff == 32'h0);
    endproperty
    a_mod_rst: assert property (p_mod_rst)
        else $error("Modulator not reset after register zero write.");

    property p_cal_start;
        r0Wr |=> (state_ff == scm_pkg::ST_CAL && cnt_ff == 16'h0);
    endproperty
    a_cal_start: assert property (p_cal_start)
        else $error("Calibration did not restart on register zero write.");

    property p_delay_after;
        $rose(state_ff == scm_pkg::ST_DELAY) |-> $past(state_ff) == scm_pkg::ST_CAL;
    endproperty
    a_delay_after: assert property (p_delay_after)
        else $error("Delay count began without a finished calibration.");

    property p_tune;
        (lockDetectKind && vtuneLocked) |-> tuneLockReadback == 2'h2 && lockDetect;
    endproperty
    a_tune: assert property (p_tune)
        else $error("Tuning lock not reported as locked.");

    property p_ref_multiplier;
        (wrEn && wrIdx == scm_pkg::IDX_CFG && newMult == 3'h2)
            |=> refMultiplier == $past(refMultiplier);
    endproperty
    a_ref_multiplier: assert property (p_ref_multiplier)
        else $error("Illegal multiplier value was stored.");

    property p_acc;
        (fracNumerator < effDen) |-> acc_ff < effDen ##1 acc_ff < effDen;
    endproperty
    a_acc: assert property (p_acc)
        else $error("Fraction accumulator exceeded the denominator.");
endmodule : scm_synth_control
`default_nettype wire

/* shared/scm_pkg.sv */
// Purpose: Shared constants for the synthesizer control block.
// Assumes: Registers are 16 bits wide, one per aligned APB word.
// Notes: Calibration lengths stand in for the analog search time.
package scm_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_REGS = 9;
    localparam logic [3:0] IDX_CTRL0 = 4'h0;
    localparam logic [3:0] IDX_CFG = 4'h1;
    localparam logic [3:0] IDX_LDDLY = 4'h2;
    localparam logic [3:0] IDX_RDIV = 4'h3;
    localparam logic [3:0] IDX_NINT = 4'h4;
    localparam logic [3:0] IDX_NUML = 4'h5;
    localparam logic [3:0] IDX_NUMH = 4'h6;
    localparam logic [3:0] IDX_DENL = 4'h7;
    localparam logic [3:0] IDX_DENH = 4'h8;
    localparam logic [3:0] IDX_STAT = 4'h9;
    localparam int CTRL0_FCAL_BIT = 0;
    localparam int CFG_DIV_LSB = 0;
    localparam int CFG_DBL_BIT = 2;
    localparam int CFG_REF_MULTIPLIER_LSB = 3;
    localparam int CFG_KIND_BIT = 6;
    localparam int CFG_MUTE_BIT = 7;
    localparam int CFG_ORD_LSB = 8;
    localparam int CFG_MUX_BIT = 11;
    localparam int CFG_PDLY_BIT = 12;
    localparam logic [NUM_REGS-1:0][15:0] REG_RST = {
        16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0028,
        16'h0101, 16'h0000, 16'h0008, 16'h0000};
    localparam logic [2:0] REF_MULTIPLIER_BYPASS = 3'h1;
    localparam logic [2:0] REF_MULTIPLIER_MIN = 3'h3;
    localparam logic [2:0] REF_MULTIPLIER_MAX = 3'h7;
    localparam logic [2:0] ORDER_MAX = 3'h4;
    localparam logic [15:0] AMP_CAL_TICKS = 16'h0010;
    localparam logic [15:0] FREQ_CAL_TICKS = 16'h0040;
    localparam logic [1:0] TUNE_LOCKED = 2'h2;
    localparam logic [1:0] TUNE_UNLOCKED = 2'h0;
    localparam logic [4:0] SPI_FRAME_LAST = 5'h17;
    localparam logic [4:0] SPI_HDR_LAST = 5'h07;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CAL = 2'b01,
        ST_DELAY = 2'b10,
        ST_LOCK = 2'b11
    } scm_lock_e;
endpackage : scm_pkg

/* shared/scm_spi_if.sv */
// Purpose: Carrier between the serial port and the register core.
// Assumes: One mclk domain.
// Notes: Read data is looked up combinationally from the held address.
`timescale 1ns/10ps
`default_nettype none
interface scm_spi_if;
    logic wrStb;
    logic [6:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic sdo;
    logic readData;
    modport slave (output wrStb, output addr, output wdata, output sdo,
        output readData, input rdata);
    modport core (input wrStb, input addr, input wdata, input sdo,
        input readData, output rdata);
endinterface : scm_spi_if
`default_nettype wire

/* rtl/scm_tick_div.sv */
// Purpose: State machine clock enable, reference divided by 1, 2, 4 or 8.
// Assumes: mclk is the reference clock.
// Notes: A tick replaces a divided clock so the block keeps one domain.
`timescale 1ns/10ps
`default_nettype none
module scm_tick_div (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] calClkDiv,
    output logic tick
);
    logic [2:0] cnt_ff;
    logic [2:0] wrapAt;

    assign wrapAt = (calClkDiv == 2'h0) ? 3'h0 :
                    (calClkDiv == 2'h1) ? 3'h1 :
                    (calClkDiv == 2'h2) ? 3'h3 : 3'h7;
    assign tick = (cnt_ff == wrapAt);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 3'h0;
        end else begin
            cnt_ff <= tick ? 3'h0 : cnt_ff + 3'h1;
        end
    end
endmodule : scm_tick_div
`default_nettype wire

/* rtl/scm_spi_slave.sv */
// Purpose: Serial programming port: 24-bit frames, read/write bit first.
// Assumes: Pins are synchronous to mclk and sck is far slower than mclk.
// Notes: Frame is rw, 7 address bits, 16 data bits, most significant first.
`timescale 1ns/10ps
`default_nettype none
module scm_spi_slave (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic sdi,
    input wire logic chipSelectN,
    scm_spi_if.slave bus
);
    logic sckQ_ff;
    logic [4:0] bitCnt_ff;
    logic [22:0] shIn_ff;
    logic [15:0] outSh_ff;
    logic isRead_ff;
    logic dataPh_ff;
    logic loaded_ff;
    logic sdo_ff;
    logic wrStb_ff;
    logic [6:0] addr_ff;
    logic [15:0] wdata_ff;
    logic rise;
    logic fall;
    localparam logic [4:0] SPI_LAST = scm_pkg::SPI_FRAME_LAST;

    assign rise = sck && !sckQ_ff && !chipSelectN;
    assign fall = !sck && sckQ_ff && !chipSelectN;
    assign bus.wrStb = wrStb_ff;
    assign bus.addr = addr_ff;
    assign bus.wdata = wdata_ff;
    assign bus.sdo = sdo_ff;
    assign bus.readData = dataPh_ff && isRead_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sckQ_ff <= 1'b0;
            bitCnt_ff <= 5'h0;
            shIn_ff <= 23'h0;
            outSh_ff <= 16'h0;
            isRead_ff <= 1'b0;
            dataPh_ff <= 1'b0;
            loaded_ff <= 1'b0;
            sdo_ff <= 1'b0;
            wrStb_ff <= 1'b0;
            addr_ff <= 7'h0;
            wdata_ff <= 16'h0;
        end else begin
            sckQ_ff <= sck;
            wrStb_ff <= 1'b0;
            if (chipSelectN) begin
                bitCnt_ff <= 5'h0;
                dataPh_ff <= 1'b0;
                isRead_ff <= 1'b0;
                loaded_ff <= 1'b0;
                sdo_ff <= 1'b0;
            end else if (rise) begin
                shIn_ff <= {shIn_ff[21:0], sdi};
                if (bitCnt_ff != SPI_LAST) begin
                    bitCnt_ff <= bitCnt_ff + 5'h1;
                end
                if (bitCnt_ff == scm_pkg::SPI_HDR_LAST) begin
                    addr_ff <= {shIn_ff[5:0], sdi};
                    isRead_ff <= shIn_ff[6];
                    dataPh_ff <= 1'b1;
                end
                if (bitCnt_ff == SPI_LAST && !isRead_ff) begin
                    wrStb_ff <= 1'b1;
                    wdata_ff <= {shIn_ff[14:0], sdi};
                end
            end else if (fall && dataPh_ff && isRead_ff) begin
                loaded_ff <= 1'b1;
                sdo_ff <= loaded_ff ? outSh_ff[15] : bus.rdata[15];
                outSh_ff <= loaded_ff ? {outSh_ff[14:0], 1'b0}
                                      : {bus.rdata[14:0], 1'b0};
            end
        end
    end

    property p_addr_quiet;
        @(posedge mclk) disable iff (!rst_n)
        (!chipSelectN && !dataPh_ff) |-> !bus.sdo;
    endproperty
    a_addr_quiet: assert property (p_addr_quiet)
        else $error("Read data shown during the address phase.");
endmodule : scm_spi_slave
`default_nettype wire

/* sim/scm_host_model.sv */
// Purpose: Serial host on the programming port, write and readback frames.
// Assumes: sck idles low between frames; each high phase is four mclk cycles, each low phase five.
// Notes: sdi toggles during read data, which the device has to ignore.
`timescale 1ns/10ps
`default_nettype none
module scm_host_model (
    input wire logic mclk,
    input wire logic muxStatusOut,
    output logic sck,
    output logic sdi,
    output logic chipSelectN
);
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        chipSelectN = 1'b1;
    end
    task automatic xfer(input logic sel, input logic [23:0] f, output logic [15:0] q);
        q = 16'h0000;
        repeat (2) @(posedge mclk);
        chipSelectN <= ~sel;
        for (int i = 0; i < 24; i++) begin
            @(posedge mclk);
            sdi <= (f[23] && i > 7) ? ~sdi : f[23 - i];
            repeat (4) @(posedge mclk);
            if (i > 7) q[23 - i] = muxStatusOut;
            sck <= 1'b1;
            repeat (4) @(posedge mclk);
            sck <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        chipSelectN <= 1'b1;
        sdi <= ~sdi;
    endtask : xfer
endmodule : scm_host_model
`default_nettype wire

/* sim/test_synth_control_lock_detect.sv */
// Purpose: Self-checking bench for the synthesizer control block.
// Assumes: APB and the serial host share mclk; small lock delays keep runs short.
// Notes: Lock time windows allow for the phase of the tick divider.
`timescale 1ns/10ps
`default_nettype none
module test_synth_control_lock_detect;
    logic mclk, rst_n, psel, penable, pwrite, sck, sdi, chipSelectN, vtuneLocked, pfdTick;
    logic pready, pslverr, muxStatusOut, rfOutEnable, modulatorReset, refDoublerEn, er;
    logic bothEdges, detectorDelaySel, calBusy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] feedbackDivide, pfdDivFactor, q;
    logic [2:0] modOrder, refMultiplier;
    logic [3:0] pfdMulFactor;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int n;
    scm_synth_control scm_synth_control_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sck(sck), .sdi(sdi), .chipSelectN(chipSelectN),
        .vtuneLocked(vtuneLocked), .pfdTick(pfdTick), .muxStatusOut(muxStatusOut),
        .rfOutEnable(rfOutEnable), .modulatorReset(modulatorReset),
        .feedbackDivide(feedbackDivide), .modOrder(modOrder), .refDoublerEn(refDoublerEn),
        .refMultiplier(refMultiplier), .bothEdges(bothEdges), .pfdMulFactor(pfdMulFactor),
        .pfdDivFactor(pfdDivFactor), .detectorDelaySel(detectorDelaySel), .calBusy(calBusy));
    scm_host_model scm_host_model_inst (.mclk(mclk), .muxStatusOut(muxStatusOut), .sck(sck),
        .sdi(sdi), .chipSelectN(chipSelectN));
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for a slave that never answers.
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdc
    function automatic logic [31:0] cfgw(int dv, int db, int m, int k, int mu, int o, int rb);
        return 32'(dv | db << 2 | m << 3 | k << 6 | mu << 7 | o << 8 | rb << 11);
    endfunction : cfgw
    task automatic t_reset;
        rdc("cfg", 12'h004, 32'h8);
        rdc("rdiv", 12'h00c, 32'h101);
        rdc("nint", 12'h010, 32'h28);
        rdc("denl", 12'h01c, 32'h1);
        apb(1'b1, 12'h024, 32'hff);
        rdc("stat", 12'h024, 32'h0);
        apb(1'b0, 12'h028, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        apb(1'b1, 12'h008, 32'hffff);
        rdc("dlymax", 12'h008, 32'hffff);
    endtask : t_reset
    task automatic t_lock(input int dv, input int fc, input int dl, input int mu, input int rs);
        int lo;
        int p;
        lo = ((fc != 0 ? 80 : 16) + dl - 1) << dv;
        p = 0;
        apb(1'b1, 12'h008, 32'(dl));
        apb(1'b1, 12'h004, cfgw(dv, 0, 1, 0, mu, 0, 0));
        apb(1'b1, 12'h000, 32'(fc));
        if (rs != 0) begin
            repeat (30) @(posedge mclk);
            apb(1'b1, 12'h000, 32'(fc));
        end
        for (n = 0; n < 3; n++) begin
            #1;
            p += int'(modulatorReset);
            @(posedge mclk);
        end
        chk("mrst", 32'h1, p);
        chk("busy", 32'h1, {31'h0, calBusy});
        chk("mute", {31'h0, mu == 0}, {31'h0, rfOutEnable});
        while (muxStatusOut !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        chk("lockt", 32'h1, {31'h0, n >= lo && n <= lo + (2 << dv) + 4});
        chk("rfon", 32'h1, {31'h0, rfOutEnable});
    endtask : t_lock
    task automatic t_vtune;
        apb(1'b1, 12'h004, cfgw(0, 0, 1, 1, 0, 0, 0));
        vtuneLocked <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("vmux1", 32'h1, {31'h0, muxStatusOut});
        apb(1'b0, 12'h024, 32'h0);
        chk("tune", 32'h2, {30'h0, rd[5:4]});
        vtuneLocked <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("vmux0", 32'h0, {31'h0, muxStatusOut});
    endtask : t_vtune
    task automatic t_ref;
        apb(1'b1, 12'h00c, 32'h0302);
        apb(1'b1, 12'h004, cfgw(0, 0, 5, 0, 0, 0, 0));
        #1;
        chk("mul5", 32'h15, {27'h0, bothEdges, pfdMulFactor});
        chk("pdiv", 32'h6, {16'h0, pfdDivFactor});
        apb(1'b1, 12'h004, cfgw(0, 0, 2, 0, 0, 0, 0));
        #1;
        chk("mulkeep", 32'h5, {29'h0, refMultiplier});
        // Doubler goes on only with the multiplier back at bypass.
        apb(1'b1, 12'h004, cfgw(0, 1, 1, 0, 0, 0, 0));
        #1;
        chk("dbl", 32'h32, {26'h0, refDoublerEn, bothEdges, pfdMulFactor});
        apb(1'b1, 12'h004, cfgw(0, 0, 1, 0, 0, 0, 0) | 32'h1000);
        #1;
        chk("plain", 32'h1, {27'h0, bothEdges, pfdMulFactor});
        chk("pdly", 32'h1, {31'h0, detectorDelaySel});
    endtask : t_ref
    task automatic fsum(output int s);
        s = 0;
        repeat (2) begin
            @(posedge mclk);
            pfdTick <= 1'b1;
            @(posedge mclk);
            pfdTick <= 1'b0;
            #1;
            s += int'(feedbackDivide);
        end
    endtask : fsum
    task automatic t_frac;
        int s;
        apb(1'b1, 12'h014, 32'h1);
        apb(1'b1, 12'h01c, 32'h2);
        apb(1'b1, 12'h004, cfgw(0, 0, 1, 0, 0, 1, 0));
        #1;
        chk("ord", 32'h1, {29'h0, modOrder});
        fsum(s);
        chk("frac", 32'd81, s);
        apb(1'b1, 12'h004, cfgw(0, 0, 1, 0, 0, 0, 0));
        fsum(s);
        chk("intonly", 32'd80, s);
        apb(1'b1, 12'h020, 32'hffff);
        rdc("denh", 12'h020, 32'hffff);
    endtask : t_frac
    task automatic t_serial;
        scm_host_model_inst.xfer(1'b1, {1'b0, 7'h02, 16'h1234}, q);
        rdc("spiw", 12'h008, 32'h1234);
        scm_host_model_inst.xfer(1'b0, {1'b0, 7'h02, 16'h5555}, q);
        rdc("spiign", 12'h008, 32'h1234);
        apb(1'b1, 12'h004, cfgw(0, 0, 1, 0, 0, 0, 1));
        scm_host_model_inst.xfer(1'b1, {1'b1, 7'h02, 16'hffff}, q);
        chk("spir", 32'h1234, {16'h0, q});
    endtask : t_serial
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        {rst_n, psel, penable, pwrite, vtuneLocked, pfdTick} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_lock(0, 0, 0, 1, 0);
        t_lock(1, 1, 3, 0, 0);
        t_lock(3, 0, 5, 1, 0);
        t_lock(2, 1, 2, 0, 1);
        t_vtune();
        t_ref();
        t_frac();
        t_serial();
        summarize();
    end
endmodule : test_synth_control_lock_detect
`default_nettype wire
